// ---- flash_rewrite_ctrl.sv ----
/*
 Flash rewrite control: both control registers, stop and power-down,
 forced abort of the erase/write sequence, three flash interrupt
 requests, the lock-disable bit and the block-inhibit bits.
 Assumes decoder events arrive as one-cycle pulses and its busy state
 as a level, all synchronous to core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_rewrite_ctrl #(
    parameter int timer_width = 12
) (
    input  wire logic       core_clk,        // Clock, 125 MHz
    input  wire logic       sys_rst,         // Sync reset, high
    input  wire logic [8:0] addr,            // Register address
    input  wire logic [7:0] wdata,           // Write data
    input  wire logic       wr_en,           // Write strobe
    input  wire logic       rd_en,           // Read strobe
    output var  logic [7:0] rdata,           // Read data, next cycle
    input  wire logic       seq_busy,        // Decoder operation running
    input  wire logic       seq_done,        // Program or erase done pulse
    input  wire logic       seq_ready_evt,   // Other busy-to-ready pulse
    input  wire logic       seq_err_evt,     // Program/erase/blank error pulse
    input  wire logic       seq_cmd_err,     // Command sequence error pulse
    input  wire logic       suspend_enter,   // Erase-suspend entry pulse
    input  wire logic       clear_status,    // Clear-status command pulse
    input  wire logic       busy_access,     // Access to area being rewritten
    input  wire logic       cmd_block_df,    // Command targets data flash
    input  wire logic [1:0] cmd_block_sel,   // Data-flash block index
    input  wire logic       low_power_req,   // Stop or wait mode entry
    output var  logic       access_allowed,  // Flash reads allowed
    output var  logic       prog_rom_read,   // Program ROM readable
    output var  logic       flash_power_on,  // Flash power enable
    output var  logic       ctrl_init,       // Control circuit reinit
    output var  logic       seq_abort,       // Sequence reset pulse
    output var  logic       suspend_clear,   // Suspend state clear pulse
    output var  logic       cmd_accept,      // Command allowed by inhibit
    output var  logic       lock_bypass,     // Skip lock check
    output var  logic       unlock_on_erase, // Erase also clears lock
    output var  logic       ready_busy_flag, // Status ready flag
    output var  logic       cmd_err_irq,     // Command error interrupt
    output var  logic       acc_err_irq,     // Access error interrupt
    output var  logic       ready_irq        // Ready interrupt
);
    initial
    begin
        if (flash_rewrite_pkg::abort_delay_cycles >= (1 << timer_width))
            $error("timer_width too small for abort delay");
    end

    // ==========================================================
    // Register decode
    logic wr_first;
    logic wr_second;
    logic wr_status;
    assign wr_first  = wr_en && (addr == flash_rewrite_pkg::ctrl_first_offset);
    assign wr_second = wr_en && (addr == flash_rewrite_pkg::ctrl_second_offset);
    assign wr_status = wr_en && (addr == flash_rewrite_pkg::status_offset);

    logic rewrite_en_reg;
    logic ew1_reg;
    logic stop_reg;
    logic cmd_err_ie_reg;
    logic acc_err_ie_reg;
    logic ready_ie_reg;
    logic lock_dis_reg;
    logic lock_armed_reg;
    logic ready_flag_reg;
    logic acc_err_flag_reg;
    logic cmd_err_flag_reg;
    logic [3:0] inhibit;

    // ==========================================================
    // First control register
    logic abort_fire;
    assign abort_fire = wr_first && wdata[flash_rewrite_pkg::abort_bit]
                        && rewrite_en_reg && !ready_busy_flag;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rewrite_en_reg <= flash_rewrite_pkg::ctrl_first_reset[1];
            ew1_reg        <= flash_rewrite_pkg::ctrl_first_reset[2];
            cmd_err_ie_reg <= flash_rewrite_pkg::ctrl_first_reset[5];
            acc_err_ie_reg <= flash_rewrite_pkg::ctrl_first_reset[6];
            ready_ie_reg   <= flash_rewrite_pkg::ctrl_first_reset[7];
        end
        else if (wr_first)
        begin
            rewrite_en_reg <= wdata[flash_rewrite_pkg::rewrite_en_bit];
            ew1_reg        <= wdata[flash_rewrite_pkg::ew1_bit];
            cmd_err_ie_reg <= wdata[flash_rewrite_pkg::cmd_err_ie_bit];
            acc_err_ie_reg <= wdata[flash_rewrite_pkg::acc_err_ie_bit];
            ready_ie_reg   <= wdata[flash_rewrite_pkg::ready_ie_bit];
        end
    end

    // Stop bit is written only while rewrite mode is on or in the write that switches it on
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            stop_reg <= flash_rewrite_pkg::ctrl_first_reset[3];
        else if (wr_first && (rewrite_en_reg || wdata[flash_rewrite_pkg::rewrite_en_bit]))
            stop_reg <= wdata[flash_rewrite_pkg::stop_bit];
    end

    // ==========================================================
    // Abort and wake timers
    logic abort_running;
    logic abort_done;
    logic wake_running;
    logic stop_fall;
    logic stop_d_reg;
    logic auto_off_reg;
    logic auto_off_d_reg;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            stop_d_reg <= 1'b0;
        else
            stop_d_reg <= stop_reg;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            auto_off_reg <= 1'b0;
        else
            auto_off_reg <= low_power_req && !rewrite_en_reg;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            auto_off_d_reg <= 1'b0;
        else
            auto_off_d_reg <= auto_off_reg;
    end

    assign stop_fall = (stop_d_reg && !stop_reg) || (auto_off_d_reg && !auto_off_reg);

    busy_timer #(
        .width (timer_width)
    ) u_abort_timer (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .start    (abort_fire),
        .cycles   (timer_width'(flash_rewrite_pkg::abort_delay_cycles)),
        .running  (abort_running),
        .done     (abort_done)
    );

    busy_timer #(
        .width (timer_width)
    ) u_wake_timer (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .start    (stop_fall),
        .cycles   (timer_width'(flash_rewrite_pkg::wake_delay_cycles)),
        .running  (wake_running),
        .done     ()
    );

    assign seq_abort     = abort_fire;
    assign suspend_clear = abort_fire;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            access_allowed <= 1'b1;
        else
            access_allowed <= !stop_reg && !auto_off_reg && !abort_running
                              && !abort_fire && !wake_running;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            prog_rom_read <= 1'b1;
        else
            prog_rom_read <= !stop_reg && !auto_off_reg && !wake_running;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            flash_power_on <= 1'b1;
            ctrl_init      <= 1'b0;
        end
        else
        begin
            flash_power_on <= !stop_reg && !auto_off_reg;
            ctrl_init      <= stop_reg;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            ready_busy_flag <= 1'b1;
        else
            ready_busy_flag <= !(seq_busy || abort_running || abort_fire
                                 || wake_running || stop_fall);
    end

    // ==========================================================
    // Second control register
    logic lock_clear;
    assign lock_clear = seq_done || seq_cmd_err || suspend_enter || !rewrite_en_reg
                        || stop_reg || abort_fire;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst || lock_clear)
            lock_dis_reg <= 1'b0;
        else if (wr_second && wdata[flash_rewrite_pkg::lock_dis_bit] && lock_armed_reg)
            lock_dis_reg <= 1'b1;
        else if (wr_second && !wdata[flash_rewrite_pkg::lock_dis_bit])
            lock_dis_reg <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            lock_armed_reg <= 1'b0;
        else if (wr_second)
            lock_armed_reg <= !wdata[flash_rewrite_pkg::lock_dis_bit];
        else if (wr_first || wr_status)
            lock_armed_reg <= 1'b0;
    end

    block_inhibit #(
        .blocks (flash_rewrite_pkg::inhibit_count)
    ) u_inhibit (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .wr          (wr_second),
        .other_wr    (wr_first || wr_status),
        .wdata       (wdata[7:4]),
        .rewrite_off (!rewrite_en_reg),
        .inhibit     (inhibit)
    );

    assign cmd_accept      = !(cmd_block_df && inhibit[cmd_block_sel]);
    assign lock_bypass     = lock_dis_reg;
    assign unlock_on_erase = lock_dis_reg;

    // ==========================================================
    // Interrupt request flags; a set wins over a clear
    logic ready_rise;
    logic ready_d_reg;
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            ready_d_reg <= 1'b1;
        else
            ready_d_reg <= ready_busy_flag;
    end
    assign ready_rise = (ready_busy_flag && !ready_d_reg) || seq_ready_evt;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            ready_flag_reg <= 1'b0;
        else if (ready_ie_reg && ready_rise)
            ready_flag_reg <= 1'b1;
        else if (wr_status && !wdata[flash_rewrite_pkg::ready_irq_bit])
            ready_flag_reg <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            acc_err_flag_reg <= 1'b0;
        else if ((acc_err_ie_reg && busy_access && !ready_busy_flag)
                 || (cmd_err_ie_reg && (seq_err_evt || seq_cmd_err)))
            acc_err_flag_reg <= 1'b1;
        else if (clear_status
                 || (wr_status && !wdata[flash_rewrite_pkg::acc_err_irq_bit]))
            acc_err_flag_reg <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            cmd_err_flag_reg <= 1'b0;
        else if (cmd_err_ie_reg && (seq_err_evt || seq_cmd_err))
            cmd_err_flag_reg <= 1'b1;
        else if (clear_status)
            cmd_err_flag_reg <= 1'b0;
    end

    assign cmd_err_irq = cmd_err_flag_reg && cmd_err_ie_reg;
    assign acc_err_irq = acc_err_flag_reg && (acc_err_ie_reg || cmd_err_ie_reg);
    assign ready_irq   = ready_flag_reg && ready_ie_reg;

    // ==========================================================
    // Read data
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            rdata <= 8'h00;
        else if (rd_en)
        begin
            unique case (addr)
                flash_rewrite_pkg::ctrl_first_offset:
                    rdata <= {ready_ie_reg, acc_err_ie_reg, cmd_err_ie_reg, 1'b0,
                              stop_reg, ew1_reg, rewrite_en_reg, 1'b0};
                flash_rewrite_pkg::ctrl_second_offset:
                    rdata <= {inhibit, lock_dis_reg, 3'h0};
                flash_rewrite_pkg::status_offset:
                    rdata <= {ready_busy_flag, 5'h00, acc_err_flag_reg, ready_flag_reg};
                default:
                    rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end
endmodule
`default_nettype wire

// ---- flash_rewrite_pkg.sv ----
/*
 Constants of the flash rewrite control block: offsets, fields,
 reset values and timing counts. Assumes a 125 MHz core clock.
*/
//
// Contract
// - Stop bit blocks access, reinitialises, powers down.
// - Stop/wait without rewrite auto powers flash off.
// - Abort resets sequence; program memory stays readable.
// - Abort during suspend also clears suspend state.
// - After abort delay, command ends, reads enabled.
// - Command error enable raises error interrupt.
// - Access error enable flags busy-area access.
// - Ready enable flags busy-to-ready transition.
// - Second register bits 0 to 2 read zero.
// - Rewrite disable clears all four inhibit bits.
// - Inhibited data-flash block ignores commands silently.
// - Lock disable bypasses check; erase unlocks block.
// - Lock disable auto-clears on listed events.
// - Ready flag low during any busy operation.
// - Abort bit 4, reads zero, needs enable+busy.
`timescale 1ns/1ns
package flash_rewrite_pkg;
    // ==========================================================
    // Register map
    localparam logic [8:0] ctrl_first_offset  = 9'h1B4;
    localparam logic [8:0] ctrl_second_offset = 9'h1B5;
    localparam logic [8:0] status_offset      = 9'h1B3;
    localparam logic [7:0] ctrl_first_reset   = 8'h00;
    localparam logic [7:0] ctrl_second_reset  = 8'h00;
    // ==========================================================
    // First control register fields
    localparam int rewrite_en_bit   = 1;
    localparam int ew1_bit          = 2;
    localparam int stop_bit         = 3;
    localparam int abort_bit        = 4;
    localparam int cmd_err_ie_bit   = 5;
    localparam int acc_err_ie_bit   = 6;
    localparam int ready_ie_bit     = 7;
    // ==========================================================
    // Second control register fields
    localparam int lock_dis_bit     = 3;
    localparam int inhibit_lsb      = 4;
    localparam int inhibit_count    = 4;
    // ==========================================================
    // Status register fields
    localparam int ready_irq_bit    = 0;
    localparam int acc_err_irq_bit  = 1;
    localparam int suspend_bit      = 6;
    localparam int ready_busy_bit   = 7;
    // ==========================================================
    // Timing
    localparam int clk_mhz             = 125;
    localparam int abort_delay_ns      = 3000;
    localparam int abort_delay_cycles  = (abort_delay_ns * clk_mhz) / 1000;
    localparam int wake_delay_ns       = 1000;
    localparam int wake_delay_cycles   = (wake_delay_ns * clk_mhz + 999) / 1000;
endpackage
`default_nettype wire

// ---- busy_timer.sv ----
/*
 Down counter holding busy for a set number of cycles.
 Assumes one-cycle start pulses; a new start restarts it.
*/
`timescale 1ns/1ns
`default_nettype none
module busy_timer #(
    parameter int width = 12
) (
    input  wire logic             core_clk, // Clock
    input  wire logic             sys_rst,  // Sync reset, high
    input  wire logic             start,    // Start pulse
    input  wire logic [width-1:0] cycles,   // Length in cycles
    output var  logic             running,  // Busy while counting
    output var  logic             done      // One-cycle end pulse
);
    initial
    begin
        if (width < 2)
            $error("busy_timer width too small");
    end

    logic [width-1:0] count_reg;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            count_reg <= '0;
        else if (start)
            count_reg <= cycles;
        else if (count_reg != '0)
            count_reg <= count_reg - 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            done <= 1'b0;
        else
            done <= !start && (count_reg == {{(width-1){1'b0}}, 1'b1});
    end

    assign running = (count_reg != '0);
endmodule
`default_nettype wire

// ---- block_inhibit.sv ----
/*
 Data-flash write-inhibit bits; a bit clears on rewrite_off, or after a write
 of 1 directly followed by a write of 0.
 Assumes one-cycle write strobes.
*/
`timescale 1ns/1ns
`default_nettype none
module block_inhibit #(
    parameter int blocks = 4
) (
    input  wire logic              core_clk,     // Clock
    input  wire logic              sys_rst,      // Sync reset, high
    input  wire logic              wr,           // Register write
    input  wire logic              other_wr,     // Any other register write
    input  wire logic [blocks-1:0] wdata,        // Written field
    input  wire logic              rewrite_off,  // Rewrite mode disabled
    output var  logic [blocks-1:0] inhibit       // Inhibit bits
);
    initial
    begin
        if (blocks < 1)
            $error("block_inhibit needs at least one block");
    end

    logic [blocks-1:0] armed_reg;

    genvar i;
    generate
        for (i = 0; i < blocks; i++)
        begin : g_blk
            always_ff @(posedge core_clk)
            begin
                if (sys_rst || rewrite_off)
                    inhibit[i] <= 1'b0;
                else if (wr && wdata[i])
                    inhibit[i] <= 1'b1;
                else if (wr && !wdata[i] && armed_reg[i])
                    inhibit[i] <= 1'b0;
            end

            always_ff @(posedge core_clk)
            begin
                if (sys_rst)
                    armed_reg[i] <= 1'b0;
                else if (wr)
                    armed_reg[i] <= wdata[i];
                else if (other_wr)
                    armed_reg[i] <= 1'b0;
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ---- flash_rewrite_chk.sv ----
/*
 Checks on the ports of the flash rewrite control block.
 Assumes one clock, sys_rst synchronous and high.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_rewrite_chk (
    input wire logic       core_clk,        // Clock
    input wire logic       sys_rst,         // Sync reset, high
    input wire logic [8:0] addr,            // Register address
    input wire logic [7:0] wdata,           // Write data
    input wire logic       wr_en,           // Write strobe
    input wire logic       rd_en,           // Read strobe
    input wire logic [7:0] rdata,           // Read data
    input wire logic       seq_done,        // Done pulse
    input wire logic       busy_access,     // Busy-area access
    input wire logic       seq_err_evt,     // Error pulse
    input wire logic       seq_cmd_err,     // Cmd error pulse
    input wire logic       cmd_block_df,    // Data-flash target
    input wire logic       access_allowed,  // Reads allowed
    input wire logic       prog_rom_read,   // Program ROM readable
    input wire logic       flash_power_on,  // Flash power
    input wire logic       seq_abort,       // Abort pulse
    input wire logic       suspend_clear,   // Suspend clear pulse
    input wire logic       cmd_accept,      // Command allowed
    input wire logic       lock_bypass,     // Lock check skipped
    input wire logic       ready_busy_flag, // Ready flag
    input wire logic       acc_err_irq      // Access error irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_abort_reads0;
        rd_en && addr == 9'h1B4 |=> rdata[4] == 1'b0;
    endproperty
    a_abort_reads0: assert property (p_abort_reads0) else $error("abort read");
    property p_unused_bits;
        rd_en && addr == 9'h1B5 |=> rdata[2:0] == 3'h0;
    endproperty
    a_unused_bits: assert property (p_unused_bits) else $error("unused bits");
    property p_abort_cause;
        seq_abort |-> wr_en && addr == 9'h1B4 && wdata[4] && !ready_busy_flag;
    endproperty
    a_abort_cause: assert property (p_abort_cause) else $error("abort cause");
    property p_abort_suspend;
        seq_abort |-> suspend_clear;
    endproperty
    a_abort_suspend: assert property (p_abort_suspend) else $error("suspend");
    property p_abort_ready;
        seq_abort |=> (!ready_busy_flag) [*8] ##[360:392] (ready_busy_flag && access_allowed);
    endproperty
    a_abort_ready: assert property (p_abort_ready) else $error("abort end");
    property p_rom_read;
        seq_abort |=> prog_rom_read [*4];
    endproperty
    a_rom_read: assert property (p_rom_read) else $error("rom read");
    property p_lock_clear;
        seq_abort || seq_done || seq_cmd_err |=> !lock_bypass;
    endproperty
    a_lock_clear: assert property (p_lock_clear) else $error("lock clear");
    property p_rewrite_off;
        wr_en && addr == 9'h1B4 && !wdata[1] |=> ##1 (cmd_accept || !cmd_block_df) && !lock_bypass;
    endproperty
    a_rewrite_off: assert property (p_rewrite_off) else $error("inhibit kept");
    property p_stop;
        wr_en && addr == 9'h1B4 && wdata[1] && wdata[3]
            |-> ##[1:3] (!access_allowed && !flash_power_on);
    endproperty
    a_stop: assert property (p_stop) else $error("stop");
    property p_acc_cause;
        $rose(acc_err_irq) |-> $past(busy_access || seq_err_evt || seq_cmd_err || wr_en);
    endproperty
    a_acc_cause: assert property (p_acc_cause) else $error("acc cause");
endmodule
`default_nettype wire

// ---- decoder_model.sv ----
/*
 Command decoder model behind the control block.
 Assumes one-cycle start and abort pulses.
*/
`timescale 1ns/1ns
`default_nettype none
module decoder_model (
    input  wire logic       core_clk,  // Clock
    input  wire logic       sys_rst,   // Sync reset, high
    input  wire logic       op_start,  // Begin an operation
    input  wire logic [9:0] op_len,    // Operation length in cycles
    input  wire logic       seq_abort, // Forced stop from the block
    output var  logic       seq_busy,  // Operation running
    output var  logic       seq_done   // Completion pulse
);
    logic [9:0] left_reg;
    always_ff @(posedge core_clk)
    begin
        seq_done <= 1'b0;
        if (sys_rst)
        begin
            seq_busy <= 1'b0;
            left_reg <= 10'h000;
        end
        else if (seq_abort)
            seq_busy <= 1'b0;
        else if (op_start)
        begin
            seq_busy <= 1'b1;
            left_reg <= op_len;
        end
        else if (seq_busy)
        begin
            left_reg <= left_reg - 10'h001;
            if (left_reg == 10'h001)
            begin
                seq_busy <= 1'b0;
                seq_done <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- flash_rewrite_ctrl_tb.sv ----
/*
 Bench for the flash rewrite control block.
 Assumes the decoder model and checker beside it.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("[ERR] t=%0t got %h exp %h", $time, (got), (exp)); \
        end \
    end
module flash_rewrite_ctrl_tb;
    localparam logic [8:0] first_a  = flash_rewrite_pkg::ctrl_first_offset;
    localparam logic [8:0] second_a = flash_rewrite_pkg::ctrl_second_offset;
    localparam logic [8:0] stat_a   = flash_rewrite_pkg::status_offset;
    localparam int         abort_n  = flash_rewrite_pkg::abort_delay_cycles;
    localparam int         wake_n   = flash_rewrite_pkg::wake_delay_cycles;
    logic       core_clk = 1'b0, sys_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic [8:0] addr = 9'h000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [4:0] pulses = 5'h00;
    logic [9:0] op_len = 10'h014;
    logic [1:0] cmd_block_sel = 2'h0;
    logic       cmd_block_df = 1'b1, low_power_req = 1'b0, seq_ready_evt = 1'b0;
    logic       suspend_enter = 1'b0, seq_busy, seq_done, ab, sc;
    logic       access_allowed, prog_rom_read, flash_power_on, ctrl_init, seq_abort;
    logic       suspend_clear, cmd_accept, lock_bypass, unlock_on_erase, ready_busy_flag;
    logic       cmd_err_irq, acc_err_irq, ready_irq;
    int         num_errors = 0, tests_run = 0;
    initial forever #4 core_clk = ~core_clk;
    flash_rewrite_ctrl flash_rewrite_ctrl_i (.*, .seq_err_evt(pulses[1]),
        .seq_cmd_err(pulses[2]), .clear_status(pulses[0]), .busy_access(pulses[3]));
    decoder_model decoder_model_i (.*, .op_start(pulses[4]));
    // ==========================================================
    // Bus and handshake tasks
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        #1;
        ab = seq_abort;
        sc = suspend_clear;
        @(posedge core_clk);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic pulse(input int k);
        @(posedge core_clk);
        pulses[k] <= 1'b1;
        @(posedge core_clk);
        pulses <= 5'h00;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic wait_rbf(input logic lvl, output int n);
        n = 0;
        while (ready_busy_flag !== lvl)
        begin
            @(posedge core_clk);
            #1;
            n++;
            if (n > 1000)
            begin
                num_errors++;
                wrap_up();
            end
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d compares %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] d;
        rd(first_a, d);
        `CHK(d, 8'h00)
        rd(second_a, d);
        `CHK(d, 8'h00)
        rd(stat_a, d);
        `CHK(d[7], 1'b1)
        rd(9'h0FF, d);
        `CHK(d, 8'h00)
    endtask
    task automatic t_abort();
        logic [7:0] d;
        int         n;
        wr(first_a, 8'h02);
        wr(first_a, 8'h12);
        `CHK(ab, 1'b0)
        wr(second_a, 8'h08);
        rd(second_a, d);
        `CHK(d, 8'h00)
        wr(second_a, 8'h00);
        wr(second_a, 8'h08);
        `CHK(lock_bypass, 1'b1)
        `CHK(unlock_on_erase, 1'b1)
        op_len <= 10'h320;
        pulse(4);
        wait_rbf(1'b0, n);
        wr(first_a, 8'h12);
        `CHK(ab, 1'b1)
        `CHK(sc, 1'b1)
        `CHK(lock_bypass, 1'b0)
        `CHK(prog_rom_read, 1'b1)
        wait_rbf(1'b1, n);
        `CHK((n >= abort_n - 2 && n <= abort_n + 5), 1'b1)
        `CHK(access_allowed, 1'b1)
        pulse(0);
        rd(first_a, d);
        `CHK(d, 8'h02)
    endtask
    task automatic t_inhibit();
        logic [7:0] d;
        wr(second_a, 8'hF0);
        wr(first_a, 8'h02);
        wr(second_a, 8'h00);
        rd(second_a, d);
        `CHK(d, 8'hF0)
        wr(second_a, 8'hF0);
        wr(second_a, 8'hE0);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge core_clk);
            cmd_block_sel <= i[1:0];
            #1;
            `CHK(cmd_accept, (i == 0))
        end
        wr(first_a, 8'h00);
        rd(second_a, d);
        `CHK(d, 8'h00)
    endtask
    task automatic t_irq();
        logic [7:0] d;
        int         n;
        wr(first_a, 8'h02);
        rd(stat_a, d);
        wr(stat_a, 8'hFE);
        wr(first_a, 8'h82);
        pulse(4);
        `CHK(ready_irq, 1'b0)
        wait_rbf(1'b1, n);
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(ready_irq, 1'b1)
        wr(stat_a, 8'hFE);
        `CHK(ready_irq, 1'b0)
        rd(stat_a, d);
        wr(stat_a, 8'hFD);
        wr(first_a, 8'h42);
        pulse(4);
        pulse(3);
        `CHK(acc_err_irq, 1'b1)
        wait_rbf(1'b1, n);
        wr(stat_a, 8'hFD);
        `CHK(acc_err_irq, 1'b0)
        for (int k = 1; k < 3; k++)
        begin
            pulse(0);
            wr(first_a, 8'h22);
            pulse(k);
            `CHK(cmd_err_irq, 1'b1)
            pulse(0);
            `CHK(cmd_err_irq, 1'b0)
        end
        wr(first_a, 8'h02);
        pulse(1);
        `CHK(cmd_err_irq, 1'b0)
        pulse(0);
    endtask
    task automatic t_stop();
        int n;
        wr(first_a, 8'h0A);
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(access_allowed, 1'b0)
        `CHK(flash_power_on, 1'b0)
        `CHK(ctrl_init, 1'b1)
        wr(first_a, 8'h02);
        repeat (2) @(posedge core_clk);
        wait_rbf(1'b1, n);
        `CHK((n >= wake_n - 8 && n <= wake_n + 2), 1'b1)
        `CHK(access_allowed, 1'b1)
        wr(first_a, 8'h00);
        low_power_req <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(flash_power_on, 1'b0)
        low_power_req <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(flash_power_on, 1'b1)
    endtask
    initial
    begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_abort();
        t_inhibit();
        t_irq();
        t_stop();
        wrap_up();
    end
endmodule
bind flash_rewrite_ctrl flash_rewrite_chk chk_i (.*);
`default_nettype wire
